/* File: src/utx_consts.svh */
/*
  Offsets, field positions, reset values and timing figures of the serial
  transmit control block.
  Assumes inclusion by bare name from the package, the bench and the checker.
*/
`ifndef UTX_CONSTS_SVH
`define UTX_CONSTS_SVH

// Register byte addresses on the AXI4-Lite slave.
`define UTX_OFS_TSC        4'h0
`define UTX_OFS_BUF        4'h4
`define UTX_OFS_DIV        4'h8
`define UTX_OFS_CTL        4'hc

// Field positions in transmit_status_control.
`define UTX_BIT_CLOCK_SOURCE_SELECT       3'd7
`define UTX_BIT_NINE       3'd6
`define UTX_BIT_TRANSMIT_ENABLE       3'd5
`define UTX_BIT_SYNC       3'd4
`define UTX_BIT_BRK        3'd3
`define UTX_BIT_HSPD       3'd2
`define UTX_BIT_EMPTY      3'd1
`define UTX_BIT_D9         3'd0

// Field positions in the port control register.
`define UTX_BIT_SERIAL_PORT_ENABLE       2'd0
`define UTX_BIT_WIDE       2'd1
`define UTX_BIT_SINGLE_RECEIVE_ENABLE       2'd2
`define UTX_BIT_CONTINUOUS_RECEIVE_ENABLE       2'd3

// Reset values.
`define UTX_RST_TSC        8'h02
`define UTX_RST_DIV        16'h0000
`define UTX_RST_CTL        4'h0

// Baud prescale: oscillator ticks per divisor step minus one.
`define UTX_PRE_LOW        4'hf
`define UTX_PRE_HIGH       4'h3

// Frame lengths counted in bit times, start and stop included.
`define UTX_BITS_8         4'ha
`define UTX_BITS_9         4'hb
`define UTX_BITS_BRK       4'he
`define UTX_BRK_ZEROS      4'hd
// Bits left when the last zero of a break is queued behind the shifter.
`define UTX_BRK_LAST       4'h3

// AXI responses.
`define UTX_RESP_OKAY      2'b00
`define UTX_RESP_SLVERR    2'b10

`endif

/* File: src/utx_pkg.sv */
/*
  Types of the serial transmit control block.
  Assumes the constants header sits beside it on the include path.
*/
package utx_pkg;
  `include "utx_consts.svh"

  typedef enum logic [1:0] {
    UTX_IDLE,
    UTX_SHIFT
  } utx_tx_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [3:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [3:0]  araddr;
    logic        rready;
  } utx_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } utx_axi_rsp_t;

  typedef struct packed {
    logic [7:0]    tsc;
    logic [3:0]    ctl;
    logic [15:0]   div;
    logic [8:0]    buf_data;
    logic          buf_full;
    logic [11:0]   shift;
    logic [3:0]    bits_left;
    logic          brk_frame;
    logic [15:0]   div_cnt;
    logic [3:0]    pre_cnt;
    logic [15:0]   div_live;
    logic [3:0]    pre_live;
    logic          line;
    logic          ck;
    utx_tx_state_t st;
    logic          aw_got;
    logic [3:0]    aw_addr;
    logic          w_got;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } utx_state_t;
endpackage

/* File: src/utx_top.sv */
/*
  Transmit side of a serial port with its control/status register, baud
  generator and an AXI4-Lite register slave.
  Assumes one 20 MHz clock, AXI inputs synchronous to it, and a pin
  wrapper that resolves the data/clock pins from the enables.
*/
// Summary of operation
// RL1 - Clock source bit ignored async; in sync mode 1 makes us clock master.
// RL2 - Nine-bit select 1 sends nine data bits, 0 sends eight.
// RL3 - Transmit enable turns the transmitter on or off; resets to 0.
// RL4 - In sync mode a set receive enable overrides transmit enable.
// RL5 - Mode bit 1 means synchronous, 0 asynchronous; resets to 0.
// RL6 - Async break request makes next frame start, 12 zeros, stop.
// RL7 - Hardware clears break request after the break has been sent.
// RL8 - Async high-speed bit picks divide by 4, else divide by 16.
// RL9 - Read-only empty flag is 1 when shift register is empty; resets 1.
// RL10 - Ninth data bit comes from the ninth-bit register field.
// RL11 - Low speed rate is oscillator/(16*(divisor+1)).
// RL12 - High speed and sync rate is oscillator/(4*(divisor+1)).
// RL13 - Writable control bits reset to 0, empty flag resets to 1.
// RL14 - LSB first, start at space, stop at mark, idle at mark.
// RL15 - Buffer moves to shift register at once if empty, else after stop.
// RL16 - Software sets port enable, which turns the transmit pin to output.
// RL17 - Empty flag sets after last stop with nothing pending, clears on load; here it also sets for one cycle as each stop bit starts with a byte pending.
// RL18 - Speed or divisor changes apply at the next generator reload.
`timescale 1ns/1ps

module utx_top
  import utx_pkg::*;
(
  // Clock and reset.
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_b,
  // AXI4-Lite register slave.
  input  wire utx_axi_req_t i_axi,
  output utx_axi_rsp_t      o_axi,
  // Serial line pins.
  output logic              o_tx_data,
  output logic              o_tx_data_oe,
  output logic              o_tx_clk,
  output logic              o_tx_clk_oe
);

  utx_state_t s_ff;
  utx_state_t nxt_s;

  logic       sync_mode;
  logic       tx_on;
  logic       tick;
  logic       load;
  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic       wr_go;
  logic [3:0] wa;
  logic [31:0] rd;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes: one write and one read outstanding at a time.

  assign aw_take = i_axi.awvalid && !s_ff.aw_got && !s_ff.bvalid;
  assign w_take  = i_axi.wvalid && !s_ff.w_got && !s_ff.bvalid;
  assign ar_take = i_axi.arvalid && !s_ff.rvalid;

  always_comb begin
    o_axi.awready = !s_ff.aw_got && !s_ff.bvalid;
    o_axi.wready  = !s_ff.w_got && !s_ff.bvalid;
    o_axi.bvalid  = s_ff.bvalid;
    o_axi.bresp   = s_ff.bresp;
    o_axi.arready = !s_ff.rvalid;
    o_axi.rvalid  = s_ff.rvalid;
    o_axi.rdata   = s_ff.rdata;
    o_axi.rresp   = s_ff.rresp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line control.

  assign sync_mode = s_ff.tsc[`UTX_BIT_SYNC]; // see RL5
  // Receive requests steal the line in sync mode.
  assign tx_on = s_ff.tsc[`UTX_BIT_TRANSMIT_ENABLE] && s_ff.ctl[`UTX_BIT_SERIAL_PORT_ENABLE]
    && !(sync_mode && (s_ff.ctl[`UTX_BIT_SINGLE_RECEIVE_ENABLE]
    || s_ff.ctl[`UTX_BIT_CONTINUOUS_RECEIVE_ENABLE])); // see RL3 // see RL4
  assign tick = (s_ff.pre_cnt == 4'h0) && (s_ff.div_cnt == 16'h0000);

  always_comb begin
    nxt_s = s_ff;
    wa    = s_ff.aw_got ? s_ff.aw_addr : i_axi.awaddr;
    rd    = 32'h0000_0000;
    wr_go = 1'b0;
    load  = 1'b0;

    // Capture address and data in either order.
    if (aw_take) begin
      nxt_s.aw_got  = 1'b1;
      nxt_s.aw_addr = i_axi.awaddr;
    end
    if (w_take) begin
      nxt_s.w_got  = 1'b1;
      nxt_s.w_data = i_axi.wdata;
      nxt_s.w_strb = i_axi.wstrb;
    end
    if (s_ff.bvalid && i_axi.bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.rvalid && i_axi.rready) begin
      nxt_s.rvalid = 1'b0;
    end

    // Baud generator; reload picks up new divisor and speed.
    if (tick) begin
      nxt_s.div_live = s_ff.div; // see RL18
      // The narrow divider only sees the low byte of the divisor.
      if (!s_ff.ctl[`UTX_BIT_WIDE]) begin
        nxt_s.div_live[15:8] = 8'h00;
      end
      nxt_s.pre_live = (sync_mode || s_ff.tsc[`UTX_BIT_HSPD]) ?
        `UTX_PRE_HIGH : `UTX_PRE_LOW; // see RL8 // see RL11 // see RL12
      nxt_s.pre_cnt  = nxt_s.pre_live;
      nxt_s.div_cnt  = nxt_s.div_live;
    end else if (s_ff.pre_cnt == 4'h0) begin
      nxt_s.pre_cnt = s_ff.pre_live;
      nxt_s.div_cnt = s_ff.div_cnt - 16'h0001;
    end else begin
      nxt_s.pre_cnt = s_ff.pre_cnt - 4'h1;
    end

    // Shifter.
    case (s_ff.st)
      UTX_IDLE: begin
        nxt_s.line = 1'b1; // see RL14
        nxt_s.ck   = 1'b1;
        if (tx_on && s_ff.buf_full) begin
          load = 1'b1; // see RL15
        end
      end
      UTX_SHIFT: begin
        if (tick) begin
          nxt_s.line      = s_ff.shift[0]; // see RL14
          nxt_s.shift     = {1'b1, s_ff.shift[11:1]};
          nxt_s.bits_left = s_ff.bits_left - 4'h1;
          // Only a sync master pulses the link clock; others keep it idle.
          nxt_s.ck        = !(sync_mode && s_ff.tsc[`UTX_BIT_CLOCK_SOURCE_SELECT]); // see RL1
          if (s_ff.bits_left == 4'h1) begin
            if (s_ff.brk_frame) begin
              nxt_s.tsc[`UTX_BIT_BRK] = 1'b0; // see RL7
            end
            nxt_s.st = UTX_IDLE;
            nxt_s.tsc[`UTX_BIT_EMPTY] = 1'b1; // see RL17
          end
        end else if (s_ff.pre_cnt == 4'h1) begin
          nxt_s.ck = 1'b1;
        end
        if (!tx_on) begin
          nxt_s.st = UTX_IDLE;
          nxt_s.line = 1'b1;
          nxt_s.tsc[`UTX_BIT_EMPTY] = 1'b1;
        end
      end
      default: nxt_s.st = UTX_IDLE;
    endcase

    if (load) begin
      nxt_s.st       = UTX_SHIFT;
      nxt_s.buf_full = 1'b0;
      nxt_s.tsc[`UTX_BIT_EMPTY] = 1'b0; // see RL9 // see RL17
      nxt_s.brk_frame = !sync_mode && s_ff.tsc[`UTX_BIT_BRK]; // see RL6
      if (nxt_s.brk_frame) begin
        nxt_s.shift     = 12'h000;
        nxt_s.bits_left = `UTX_BITS_BRK;
      end else if (s_ff.tsc[`UTX_BIT_NINE]) begin
        nxt_s.shift     = {2'b11, s_ff.buf_data, 1'b0}; // see RL2 // see RL10
        nxt_s.bits_left = `UTX_BITS_9;
      end else begin
        nxt_s.shift     = {3'b111, s_ff.buf_data[7:0], 1'b0}; // see RL2
        nxt_s.bits_left = `UTX_BITS_8;
      end
    end
    // Break: the twelve-bit shifter runs out of zeros one bit early, so the
    // fill bit is held low once more before the stop bit.
    if (s_ff.st == UTX_SHIFT && s_ff.brk_frame && tick
        && s_ff.bits_left == `UTX_BRK_LAST) begin
      nxt_s.shift[0] = 1'b0; // see RL6
    end

    // Register writes once both halves are in.
    if (nxt_s.aw_got && nxt_s.w_got && !s_ff.bvalid) begin
      wr_go        = 1'b1;
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got  = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp  = `UTX_RESP_OKAY;
    end
    if (wr_go) begin
      wa = aw_take ? i_axi.awaddr : s_ff.aw_addr;
      if (wa == `UTX_OFS_TSC) begin
        if (nxt_s.w_strb[0]) begin
          // Empty flag is read-only.
          nxt_s.tsc = {nxt_s.w_data[7:2], nxt_s.tsc[`UTX_BIT_EMPTY],
            nxt_s.w_data[0]}; // see RL1
        end
      end else if (wa == `UTX_OFS_BUF) begin
        if (nxt_s.w_strb[0]) begin
          nxt_s.buf_data[7:0] = nxt_s.w_data[7:0];
          nxt_s.buf_full      = 1'b1;
        end
      end else if (wa == `UTX_OFS_DIV) begin
        if (nxt_s.w_strb[0]) begin
          nxt_s.div[7:0] = nxt_s.w_data[7:0];
        end
        if (nxt_s.w_strb[1]) begin
          nxt_s.div[15:8] = nxt_s.w_data[15:8];
        end
      end else if (wa == `UTX_OFS_CTL) begin
        if (nxt_s.w_strb[0]) begin
          nxt_s.ctl = nxt_s.w_data[3:0];
        end
      end else begin
        nxt_s.bresp = `UTX_RESP_SLVERR;
      end
    end
    nxt_s.buf_data[8] = nxt_s.tsc[`UTX_BIT_D9]; // see RL10

    // Register reads.
    if (ar_take) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = `UTX_RESP_OKAY;
      if (i_axi.araddr == `UTX_OFS_TSC) begin
        rd = {24'h000000, s_ff.tsc}; // see RL9
      end else if (i_axi.araddr == `UTX_OFS_BUF) begin
        rd = {23'h000000, s_ff.buf_full, s_ff.buf_data[7:0]};
      end else if (i_axi.araddr == `UTX_OFS_DIV) begin
        rd = {16'h0000, s_ff.div};
      end else if (i_axi.araddr == `UTX_OFS_CTL) begin
        rd = {28'h0000000, s_ff.ctl};
      end else begin
        nxt_s.rresp = `UTX_RESP_SLVERR;
      end
      nxt_s.rdata = rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; control bits clear, empty flag sets on reset.

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_ff          <= '0;
      s_ff.tsc      <= `UTX_RST_TSC; // see RL13
      s_ff.div      <= `UTX_RST_DIV;
      s_ff.ctl      <= `UTX_RST_CTL;
      s_ff.line     <= 1'b1;
      s_ff.ck       <= 1'b1;
      s_ff.st       <= UTX_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins: port enable makes the data pin an output.

  assign o_tx_data    = s_ff.line;
  assign o_tx_data_oe = s_ff.ctl[`UTX_BIT_SERIAL_PORT_ENABLE]; // see RL16
  // Only a sync master drives the link clock.
  assign o_tx_clk     = s_ff.ck;
  assign o_tx_clk_oe  = s_ff.ctl[`UTX_BIT_SERIAL_PORT_ENABLE] && sync_mode
    && s_ff.tsc[`UTX_BIT_CLOCK_SOURCE_SELECT]; // see RL1

endmodule

/* File: verification/uart_tx_control_baud_test.sv */
/*
  Self-checking bench of the serial transmit control block.
  Assumes the package, the checker and the remote receiver compiled first.
*/
`timescale 1ns/1ps
`include "utx_consts.svh"

module uart_tx_control_baud_test
  import utx_pkg::*;
  ;
  logic         ref_clk = 1'b0;
  logic         rst_b = 1'b0;
  utx_axi_req_t req = '0;
  utx_axi_rsp_t rsp;
  logic         tx_data;
  logic         tx_data_oe;
  logic         tx_clk;
  logic         tx_clk_oe;
  int           err_total = 0;
  int           checks_done = 0;
  int           per = 32;
  int           nbits = 8;
  logic [15:0]  word;
  logic         stop_ok;
  int           count;
  logic [31:0]  rdat;
  logic [1:0]   resp;

  utx_top DUT (
    .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_axi(req), .o_axi(rsp),
    .o_tx_data(tx_data), .o_tx_data_oe(tx_data_oe),
    .o_tx_clk(tx_clk), .o_tx_clk_oe(tx_clk_oe));
  utx_line_rx remote (
    .i_clk(ref_clk), .i_line(tx_data), .i_per(per), .i_nbits(nbits),
    .o_word(word), .o_stop_ok(stop_ok), .o_count(count));

  always #25 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Handshakes are judged mid-cycle, where inputs and readies are settled.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w, b;
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1'b1;
    do begin
      @(negedge ref_clk);
      aw = req.awvalid && rsp.awready;
      w = req.wvalid && rsp.wready;
      b = rsp.bvalid;
      @(posedge ref_clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end while (!b);
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar, v;
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    do begin
      @(negedge ref_clk);
      ar = req.arvalid && rsp.arready;
      v = rsp.rvalid; d = rsp.rdata; r = rsp.rresp;
      @(posedge ref_clk);
      if (ar) req.arvalid <= 1'b0;
    end while (!v);
    req.rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`UTX_OFS_TSC, rdat, resp);
    check(rdat, 32'h2);
    rd(`UTX_OFS_DIV, rdat, resp);
    check(rdat, 32'h0);
    rd(`UTX_OFS_CTL, rdat, resp);
    check(rdat, 32'h0);
    wr(`UTX_OFS_TSC, 32'h0fd);
    rd(`UTX_OFS_TSC, rdat, resp);
    check(32'(rdat[1]), 32'h1);
    rd(4'h2, rdat, resp);
    check(32'(resp), 32'h2);
  endtask

  // Divisor 1 gives bit periods of 32 clocks slow and 8 clocks fast.
  task automatic t_frame(input logic nine, input logic hs,
                         input logic [8:0] d);
    int c;
    c = count;
    per = (hs ? 4 : 16) * 2;
    nbits = nine ? 9 : 8;
    wr(`UTX_OFS_DIV, 32'h1);
    wr(`UTX_OFS_TSC, {24'h0, 1'b0, nine, 1'b1, 2'b00, hs, 1'b0, d[8]});
    wr(`UTX_OFS_BUF, {23'h0, d});
    rd(`UTX_OFS_TSC, rdat, resp);
    check(32'(rdat[1]), 32'h0);
    wait (count == c + 1);
    check(32'(word[8:0] & {nine, 8'hff}), 32'(d & {nine, 8'hff}));
    check(32'(stop_ok), 32'h1);
    check(32'(tx_data_oe), 32'h1);
  endtask

  task automatic t_b2b();
    int c;
    c = count;
    per = 32;
    nbits = 8;
    wr(`UTX_OFS_TSC, 32'h20);
    wr(`UTX_OFS_BUF, 32'h0c3);
    wr(`UTX_OFS_BUF, 32'h05a);
    wait (count == c + 1);
    check(32'(word[7:0]), 32'hc3);
    wait (count == c + 2);
    check(32'(word[7:0]), 32'h5a);
  endtask

  task automatic t_break();
    int c;
    c = count;
    nbits = 12;
    wr(`UTX_OFS_TSC, 32'h28);
    wr(`UTX_OFS_BUF, 32'h0ff);
    @(negedge tx_data);
    repeat (per) @(posedge ref_clk);
    rd(`UTX_OFS_TSC, rdat, resp);
    check(32'(rdat[1]), 32'h0);
    check(32'(rdat[3]), 32'h1);
    wait (count == c + 1);
    check(32'(word[11:0]), 32'h0);
    check(32'(stop_ok), 32'h1);
    repeat (per) @(posedge ref_clk);
    rd(`UTX_OFS_TSC, rdat, resp);
    check(rdat & 32'h8, 32'h0);
  endtask

  task automatic t_refuse();
    int lows;
    lows = 0;
    wr(`UTX_OFS_TSC, 32'h0);
    wr(`UTX_OFS_BUF, 32'h000);
    wr(`UTX_OFS_CTL, 32'h5);
    wr(`UTX_OFS_TSC, 32'hb0);
    wr(`UTX_OFS_BUF, 32'h000);
    repeat (96) begin
      @(negedge ref_clk);
      lows += !tx_data;
    end
    check(lows, 0);
    check(32'(tx_clk_oe), 32'h1);
    @(posedge ref_clk);
    wr(`UTX_OFS_TSC, 32'h80);
    @(negedge ref_clk);
    check(32'(tx_clk_oe), 32'h0);
  endtask

  task automatic conclude();
    $display("checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(50 * 30000);
    err_total++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    wr(`UTX_OFS_CTL, 32'h1);
    t_frame(1'b0, 1'b0, 9'h0a5);
    t_frame(1'b1, 1'b1, 9'h13c);
    t_b2b();
    t_break();
    t_refuse();
    conclude();
  end
endmodule

/* File: verification/utx_line_rx.sv */
/*
  Remote serial receiver that samples the line in mid-bit.
  Assumes the bench sets bit period and data count before each frame.
*/
`timescale 1ns/1ps

module utx_line_rx (
  // Clock and line.
  input wire logic   i_clk,
  input wire logic   i_line,
  // Frame setup.
  input int          i_per,
  input int          i_nbits,
  // Result.
  output logic [15:0] o_word = 16'h0000,
  output logic        o_stop_ok = 1'b0,
  output int          o_count = 0
);
  // Mid-bit sampling tolerates half a bit of timing error only.
  always begin
    @(negedge i_line);
    repeat (i_per / 2) @(posedge i_clk);
    for (int k = 0; k < i_nbits; k++) begin
      repeat (i_per) @(posedge i_clk);
      o_word[k] = i_line;
    end
    repeat (i_per) @(posedge i_clk);
    o_stop_ok = i_line;
    o_count++;
  end
endmodule

/* File: verification/utx_top_chk.sv */
/*
  Port checker for the serial transmit control block.
  Assumes it is bound onto utx_top with the package compiled first.
*/
`timescale 1ns/1ps
`include "utx_consts.svh"

module utx_chk
  import utx_pkg::*;
(
  // Clock and reset.
  input wire logic         i_ref_clk,
  input wire logic         i_rst_b,
  // Register bus.
  input wire utx_axi_req_t i_axi,
  input wire utx_axi_rsp_t o_axi,
  // Serial pins.
  input wire logic         o_tx_data,
  input wire logic         o_tx_data_oe,
  input wire logic         o_tx_clk,
  input wire logic         o_tx_clk_oe
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  logic busy_rd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // A status read taken while the line is low must find the shifter full.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_rd_ff <= 1'b0;
    end else begin
      busy_rd_ff <= i_axi.arvalid && o_axi.arready && !o_tx_data &&
                    (i_axi.araddr == `UTX_OFS_TSC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  rst_idle_a: assert property (
    !$past(i_rst_b) |-> o_tx_data && !o_tx_data_oe && !o_axi.bvalid)
    else $error("Line or bus not idle after reset.");
  idle_mark_a: assert property (
    !o_tx_data_oe |-> o_tx_data)
    else $error("Line left mark while port is off.");
  clk_oe_a: assert property (
    o_tx_clk_oe |-> o_tx_data_oe)
    else $error("Link clock driven while port is off.");
  clk_idle_a: assert property (
    !o_tx_clk_oe |-> o_tx_clk)
    else $error("Link clock moved while not master.");
  start_len_a: assert property (
    $fell(o_tx_data) |=> !o_tx_data [*3])
    else $error("Bit shorter than four clocks.");
  busy_empty_a: assert property (
    busy_rd_ff |-> o_axi.rvalid && !o_axi.rdata[`UTX_BIT_EMPTY])
    else $error("Empty flag set while shifting.");
  rd_resp_a: assert property (
    i_axi.arvalid && o_axi.arready |=> o_axi.rvalid)
    else $error("Read answer late.");
  wr_resp_a: assert property (
    i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready
    |=> o_axi.bvalid)
    else $error("Write answer late.");

  cov_long_low: cover property ($fell(o_tx_data) ##1 !o_tx_data [*8]);
  cov_master: cover property (o_tx_clk_oe);
  cov_busy: cover property (busy_rd_ff);
endmodule

bind utx_top utx_chk chk (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_axi(i_axi), .o_axi(o_axi),
  .o_tx_data(o_tx_data), .o_tx_data_oe(o_tx_data_oe),
  .o_tx_clk(o_tx_clk), .o_tx_clk_oe(o_tx_clk_oe));
